// ### inc/shsp_pkg.sv
package shsp_pkg;

	// Bus address chosen by the two straps is this base plus {high strap, low strap}.
	localparam logic [6:0] I2C_BASE_ADDR = 7'h16;
	localparam logic [6:0] OWN_ADDR_RESET = 7'h16;

	// Bit counter positions of both engines: eight data bits, then the I2C ninth clock.
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_DONE = 4'h9;
	localparam logic [3:0] IBIT_RESET = 4'h0;
	localparam logic [2:0] SBIT_RESET = 3'h0;
	localparam logic [2:0] SBIT_LAST = 3'h7;

	// Pin synchroniser reset: clock, data and select high, straps low; edge history idle high.
	localparam logic [4:0] SYNC_RESET = 5'h1C;
	localparam logic [1:0] EDGE_RESET = 2'h3;

	// Register pointer and register store geometry.
	localparam int REG_ADDR_W = 8;
	localparam int REG_DEPTH = 256;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// In the serial-peripheral command byte, this bit set asks for a read.
	localparam int SPI_CMD_READ_POS = 0;

	// Longest time from select release to a floating data output.
	localparam int SYS_CLK_PERIOD_NS = 10;
	localparam int T_CHZ_NS = 80;
	localparam int CHZ_CYCLES = (T_CHZ_NS / SYS_CLK_PERIOD_NS < 1) ? 1 : T_CHZ_NS / SYS_CLK_PERIOD_NS;

	typedef enum logic [2:0] {I_IDLE, I_DEVADR, I_REGADR, I_WDATA, I_RDATA} shsp_i2c_state_t;
	typedef enum logic [1:0] {S_CMD, S_ADDR, S_DATA} shsp_spi_phase_t;

	// One register write as it leaves the port.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} shsp_wr_t;

endpackage

// ### design/shsp_regmem.sv
`timescale 1ns/1ps
module shsp_regmem (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic wrValid,
	input shsp_pkg::shsp_wr_t wr,
	input wire logic [shsp_pkg::REG_ADDR_W-1:0] rdAddr,
	output logic [7:0] rdData
);
	import shsp_pkg::*;

	logic [7:0] mem [REG_DEPTH];
	logic [7:0] rdData_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Storage is not reset, so registers power up undefined until first written.
	always_ff @(posedge sys_clk) begin
		if (ce && wrValid) begin
			mem[wr.addr] <= wr.data;
		end
	end

	// Read data is registered, one cycle behind the address.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdData_reg <= BYTE_RESET;
		end else if (ce) begin
			rdData_reg <= mem[rdAddr];
		end
	end

	assign rdData = rdData_reg;

endmodule // shsp_regmem

// ### design/shsp_port.sv
`timescale 1ns/1ps
// Function
// - Write: START, address with write bit, ack, register address, data bytes, STOP.
// - Write data lands at the given register, then each next higher one.
// - Read: address phase, repeated START, address with read bit, ack, then data.
// - Controller acks to continue reading incremented addresses; no-ack plus STOP ends.
// - Bus address is 0x16 to 0x19, chosen by the two strap pins.
// - High strap adds two to the base address, low strap adds one; direction bit last.
// - Serial-peripheral port accepts clock modes 0 and 3 alike.
// - Serial data output floats whenever chip select is high.
// - Serial data output starts driving only after a clock edge while selected.
// - Chip select picks the interface; low selects the serial-peripheral port.
// - Serial-peripheral bytes go to incrementing addresses while select stays low.
module shsp_port (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic sclSckPin,
	input wire logic sdaSiIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic addrStrapLowPin,
	output logic soOut,
	output logic soOe,
	input wire logic addrStrapHighPin,
	input wire logic chipSelectN,
	output shsp_pkg::shsp_wr_t regWr,
	output logic regWrValid
);
	import shsp_pkg::*;

	localparam int CHZ_BOUND = CHZ_CYCLES;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; order is {scl/sck, sda/si, select, high strap, low strap}.
	logic [4:0] pinRaw;
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic [1:0] prev_reg;
	logic sclS, sdaS, csS, hiS, loS;

	assign pinRaw = {sclSckPin, sdaSiIn, chipSelectN, addrStrapHighPin, addrStrapLowPin};

	// Only the second stage and the delayed copy feed any logic.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sync1_reg <= SYNC_RESET;
			sync2_reg <= SYNC_RESET;
			prev_reg <= EDGE_RESET;
		end else if (ce) begin
			sync1_reg <= pinRaw;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg[4:3];
		end
	end

	assign {sclS, sdaS, csS, hiS, loS} = sync2_reg;

	logic sclRise, sclFall, startDet, stopDet, i2cMode, spiSel;

	// The clock pin is shared, so the same edges serve both engines.
	assign sclRise = sclS & ~prev_reg[1];
	assign sclFall = ~sclS & prev_reg[1];
	assign startDet = sclS & prev_reg[1] & prev_reg[0] & ~sdaS;
	assign stopDet = sclS & prev_reg[1] & ~prev_reg[0] & sdaS;
	assign i2cMode = csS;
	assign spiSel = ~csS;

	////////////////////////////////////////////////////////////////////////////////
	// Protocol state of both engines and the shared register pointer.
	shsp_i2c_state_t iState_reg, iState_next;
	logic [3:0] iBit_reg, iBit_next;
	logic [7:0] iRx_reg, iRx_next, iTx_reg, iTx_next;
	logic iRead_reg, iRead_next, iMAck_reg, iMAck_next, sdaOe_reg, sdaOe_next;
	logic [6:0] ownAddr_reg, ownAddr_next;
	shsp_spi_phase_t sPhase_reg, sPhase_next;
	logic [2:0] sBit_reg, sBit_next;
	logic [7:0] sRx_reg, sRx_next, sTx_reg, sTx_next, sByte;
	logic sRead_reg, sRead_next, sLoad_reg, sLoad_next;
	logic soBit_reg, soBit_next, soDrive_reg, soDrive_next;
	logic [7:0] ptr_reg, ptr_next, rdData;
	shsp_wr_t wr_reg, wr_next;
	logic wrValid_reg, wrValid_next;

	assign sByte = {sRx_reg[6:0], sdaS};

	always_comb begin
		iState_next = iState_reg;
		iBit_next = iBit_reg;
		iRx_next = iRx_reg;
		iTx_next = iTx_reg;
		iRead_next = iRead_reg;
		iMAck_next = iMAck_reg;
		sdaOe_next = sdaOe_reg;
		ownAddr_next = ownAddr_reg;
		sPhase_next = sPhase_reg;
		sBit_next = sBit_reg;
		sRx_next = sRx_reg;
		sTx_next = sTx_reg;
		sRead_next = sRead_reg;
		sLoad_next = sLoad_reg;
		soBit_next = soBit_reg;
		soDrive_next = soDrive_reg;
		ptr_next = ptr_reg;
		wr_next = wr_reg;
		wrValid_next = 1'b0;
		// I2C engine; it sleeps while the serial-peripheral port is selected.
		if (!i2cMode) begin
			iState_next = I_IDLE;
			sdaOe_next = 1'b0;
		end else if (startDet) begin
			// A repeated START keeps the pointer, so a read follows the address phase.
			iState_next = I_DEVADR;
			iBit_next = IBIT_RESET;
			sdaOe_next = 1'b0;
			ownAddr_next = I2C_BASE_ADDR + {5'h00, hiS, loS};
		end else if (stopDet) begin
			iState_next = I_IDLE;
			sdaOe_next = 1'b0;
		end else if (iState_reg != I_IDLE) begin
			if (sclRise) begin
				if (iBit_reg < BIT_ACK) begin
					iRx_next = {iRx_reg[6:0], sdaS};
				end else if (iState_reg == I_RDATA) begin
					iMAck_next = ~sdaS;
				end
				iBit_next = iBit_reg + 4'h1;
			end else if (sclFall) begin
				if (iBit_reg == BIT_ACK) begin
					sdaOe_next = 1'b0;
					case (iState_reg)
						I_DEVADR: begin
							if (iRx_reg[7:1] == ownAddr_reg) begin
								sdaOe_next = 1'b1;
								iRead_next = iRx_reg[0];
							end else begin
								iState_next = I_IDLE;
							end
						end
						I_REGADR: begin
							sdaOe_next = 1'b1;
							ptr_next = iRx_reg;
						end
						I_WDATA: begin
							sdaOe_next = 1'b1;
							wr_next = '{addr: ptr_reg, data: iRx_reg};
							wrValid_next = 1'b1;
							ptr_next = ptr_reg + 8'h01;
						end
						default: begin
							sdaOe_next = 1'b0;
						end
					endcase
				end else if (iBit_reg == BIT_DONE) begin
					iBit_next = IBIT_RESET;
					sdaOe_next = 1'b0;
					case (iState_reg)
						I_DEVADR: begin
							if (iRead_reg) begin
								iState_next = I_RDATA;
								iTx_next = rdData;
								sdaOe_next = ~rdData[7];
								ptr_next = ptr_reg + 8'h01;
							end else begin
								iState_next = I_REGADR;
							end
						end
						I_REGADR: iState_next = I_WDATA;
						I_RDATA: begin
							if (iMAck_reg) begin
								iTx_next = rdData;
								sdaOe_next = ~rdData[7];
								ptr_next = ptr_reg + 8'h01;
							end else begin
								iState_next = I_IDLE;
							end
						end
						default: iState_next = iState_reg;
					endcase
				end else if (iState_reg == I_RDATA) begin
					// Open drain: a one is sent by letting go of the line.
					sdaOe_next = ~iTx_reg[~iBit_reg[2:0]];
				end
			end
		end
		// Serial-peripheral engine: sample on rising, shift on falling, for either idle level.
		if (!spiSel) begin
			sPhase_next = S_CMD;
			sBit_next = SBIT_RESET;
			sLoad_next = 1'b0;
			soDrive_next = 1'b0;
		end else if (sclRise) begin
			soDrive_next = 1'b1;
			sRx_next = sByte;
			sBit_next = sBit_reg + 3'h1;
			if (sBit_reg == SBIT_LAST) begin
				case (sPhase_reg)
					S_CMD: begin
						sRead_next = sByte[SPI_CMD_READ_POS];
						sPhase_next = S_ADDR;
					end
					S_ADDR: begin
						ptr_next = sByte;
						sPhase_next = S_DATA;
						sLoad_next = sRead_reg;
					end
					default: begin
						if (sRead_reg) begin
							sLoad_next = 1'b1;
						end else begin
							wr_next = '{addr: ptr_reg, data: sByte};
							wrValid_next = 1'b1;
							ptr_next = ptr_reg + 8'h01;
						end
					end
				endcase
			end
		end else if (sclFall) begin
			soDrive_next = 1'b1;
			if (sLoad_reg) begin
				sTx_next = rdData;
				soBit_next = rdData[7];
				sLoad_next = 1'b0;
				ptr_next = ptr_reg + 8'h01;
			end else begin
				soBit_next = sTx_reg[~sBit_reg];
			end
		end
	end

	// Registers of both engines; all of them hold while the clock enable is low.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			iState_reg <= I_IDLE;
			iBit_reg <= IBIT_RESET;
			iRx_reg <= BYTE_RESET;
			iTx_reg <= BYTE_RESET;
			iRead_reg <= 1'b0;
			iMAck_reg <= 1'b0;
			sdaOe_reg <= 1'b0;
			ownAddr_reg <= OWN_ADDR_RESET;
			sPhase_reg <= S_CMD;
			sBit_reg <= SBIT_RESET;
			sRx_reg <= BYTE_RESET;
			sTx_reg <= BYTE_RESET;
			sRead_reg <= 1'b0;
			sLoad_reg <= 1'b0;
			soBit_reg <= 1'b0;
			soDrive_reg <= 1'b0;
			ptr_reg <= PTR_RESET;
			wr_reg <= '{addr: PTR_RESET, data: BYTE_RESET};
			wrValid_reg <= 1'b0;
		end else if (ce) begin
			iState_reg <= iState_next;
			iBit_reg <= iBit_next;
			iRx_reg <= iRx_next;
			iTx_reg <= iTx_next;
			iRead_reg <= iRead_next;
			iMAck_reg <= iMAck_next;
			sdaOe_reg <= sdaOe_next;
			ownAddr_reg <= ownAddr_next;
			sPhase_reg <= sPhase_next;
			sBit_reg <= sBit_next;
			sRx_reg <= sRx_next;
			sTx_reg <= sTx_next;
			sRead_reg <= sRead_next;
			sLoad_reg <= sLoad_next;
			soBit_reg <= soBit_next;
			soDrive_reg <= soDrive_next;
			ptr_reg <= ptr_next;
			wr_reg <= wr_next;
			wrValid_reg <= wrValid_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register store; the pointer is stable for many cycles before any byte load.
	shsp_regmem u_regmem (
		.sys_clk(sys_clk),
		.srst(srst),
		.ce(ce),
		.wrValid(wrValid_reg),
		.wr(wr_reg),
		.rdAddr(ptr_reg),
		.rdData(rdData)
	);

	// SDA only ever pulls low; the select gate floats SO within three cycles of release.
	assign sdaOut = 1'b0;
	assign sdaOe = sdaOe_reg;
	assign soOut = soBit_reg;
	assign soOe = soDrive_reg & spiSel;
	assign regWr = wr_reg;
	assign regWrValid = wrValid_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the pin behaviour and the pointer.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst || !ce);

	sequence seqAddrDecide;
		i2cMode && !startDet && !stopDet && iState_reg == I_DEVADR && sclFall && iBit_reg == BIT_ACK;
	endsequence

	sequence seqReadNext;
		i2cMode && !startDet && !stopDet && iState_reg == I_RDATA && sclFall && iBit_reg == BIT_DONE && iMAck_reg;
	endsequence

	AST_ACK_OWN: assert property (seqAddrDecide ##0 (iRx_reg[7:1] == ownAddr_reg) |=> sdaOe)
		else $error("own address not acknowledged");
	AST_NACK_FOREIGN: assert property (seqAddrDecide ##0 (iRx_reg[7:1] != ownAddr_reg) |=> !sdaOe && iState_reg == I_IDLE)
		else $error("foreign address not ignored");
	AST_IDLE_QUIET: assert property (iState_reg == I_IDLE |-> !sdaOe)
		else $error("SDA driven while idle");
	AST_STRAP_ADDR: assert property (i2cMode && startDet |=> ownAddr_reg == I2C_BASE_ADDR + {5'h00, $past(hiS), $past(loS)})
		else $error("bus address does not follow the straps");
	AST_WR_INC: assert property (wrValid_reg |-> ptr_reg == wr_reg.addr + 8'h01)
		else $error("pointer did not step after a write");
	AST_RD_INC: assert property (seqReadNext |=> ptr_reg == $past(ptr_reg) + 8'h01 && iState_reg == I_RDATA)
		else $error("pointer did not step after an acked read byte");
	AST_STOP_IDLE: assert property (i2cMode && stopDet |=> iState_reg == I_IDLE && !sdaOe)
		else $error("STOP did not end the transfer");
	AST_CS_RELEASE: assert property ($rose(chipSelectN) |-> ##[1:CHZ_BOUND] !soOe)
		else $error("SO not released after select rose");
	AST_NO_EARLY_DRIVE: assert property (spiSel && !soOe && !sclRise && !sclFall |=> !soOe)
		else $error("SO driven without a clock edge");
	AST_SPI_SAMPLE: assert property (spiSel && sclRise |=> sRx_reg[0] == $past(sdaS))
		else $error("SI not sampled on the rising edge");
	AST_SPI_INC: assert property (spiSel && sclFall && sLoad_reg |=> ptr_reg == $past(ptr_reg) + 8'h01)
		else $error("pointer did not step after a serial read byte");
	AST_MODE_SEL: assert property (!i2cMode |=> !sdaOe)
		else $error("I2C drives SDA while the serial port is selected");

endmodule // shsp_port

// ### tb/shsp_host_model.sv
`timescale 1ns/1ps
// Host controller model: drives the shared clock pin, the select and the data line.
// Open-drain data is pulled low through sdaLow; the bench resolves the wire.
module shsp_host_model (
	output logic scl,
	output logic sdaLow,
	output logic csN,
	input wire logic sda,
	input wire logic so
);
	localparam realtime H = 62.5;
	localparam realtime Q = 31.25;

	// Idle bus: clock high, data released, I2C port chosen.
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
		csN = 1'b1;
	end

	// Start, or a repeated start when the clock is low.
	task automatic start();
		sdaLow = 1'b0;
		#Q scl = 1'b1;
		#H sdaLow = 1'b1;
		#H scl = 1'b0;
		#Q;
	endtask

	// Data moves only while the clock is low, so no byte looks like a start or stop.
	task automatic sendByte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sdaLow = ~b[i];
			#Q scl = 1'b1;
			#H scl = 1'b0;
			#Q;
		end
		sdaLow = 1'b0;
		#Q scl = 1'b1;
		#H ack = ~sda;
		scl = 1'b0;
		#Q;
	endtask

	// Reads one byte, then acknowledges only when another is wanted.
	task automatic recvByte(input logic more, output logic [7:0] d);
		sdaLow = 1'b0;
		for (int i = 0; i < 8; i++) begin
			#Q scl = 1'b1;
			#H d = {d[6:0], sda};
			scl = 1'b0;
			#Q;
		end
		sdaLow = more;
		#Q scl = 1'b1;
		#H scl = 1'b0;
		#Q;
	endtask

	task automatic stop();
		sdaLow = 1'b1;
		#Q scl = 1'b1;
		#H sdaLow = 1'b0;
		#H;
	endtask

	// The clock idles at the mode's level before select falls, so mode 3 opens with a fall.
	task automatic spiBegin(input logic m3);
		scl = m3;
		#H csN = 1'b0;
		#H;
	endtask

	task automatic spiByte(input logic [7:0] b, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			scl = 1'b0;
			sdaLow = ~b[i];
			#H scl = 1'b1;
			d = {d[6:0], so};
			#H;
		end
	endtask

	task automatic spiEnd(input logic m3);
		sdaLow = 1'b0;
		scl = m3;
		#H csN = 1'b1;
		#H scl = 1'b1;
		#H;
	endtask
endmodule // shsp_host_model

// ### tb/shsp_port_tb.sv
`timescale 1ns/1ps
// Bench for the host serial port: I2C and serial-peripheral traffic from a host model.
module shsp_port_tb;
	import shsp_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic strapLow = 1'b0;
	logic strapHigh = 1'b0;
	logic scl, sdaLow, csN, sdaOut, sdaOe, soOut, soOe, regWrValid, ack;
	logic [7:0] d;
	shsp_wr_t regWr;
	shsp_wr_t wq[$];
	int miscompares = 0;
	int nTests = 0;
	int cycles = 0;
	// Pull-up on the data line; the strap resistor sets the level of a floating output.
	wire logic sdaPin = (sdaOe ? sdaOut : 1'b1) & ~sdaLow;
	wire logic soPin = soOe ? soOut : strapLow;

	always #5 sys_clk = ~sys_clk;

	shsp_port uut (
		.sys_clk(sys_clk),
		.srst(srst),
		.ce(ce),
		.sclSckPin(scl),
		.sdaSiIn(sdaPin),
		.sdaOut(sdaOut),
		.sdaOe(sdaOe),
		.addrStrapLowPin(soPin),
		.soOut(soOut),
		.soOe(soOe),
		.addrStrapHighPin(strapHigh),
		.chipSelectN(csN),
		.regWr(regWr),
		.regWrValid(regWrValid)
	);

	shsp_host_model host (
		.scl(scl),
		.sdaLow(sdaLow),
		.csN(csN),
		.sda(sdaPin),
		.so(soPin)
	);

	// Every register write leaving the port is queued for the scenarios to judge.
	always @(posedge sys_clk) begin
		if (regWrValid === 1'b1) begin
			wq.push_back(regWr);
		end
	end

	// Cuts a hung run short; the run needs about 8000 cycles.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		nTests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// An empty queue yields zero, which no expected write in this bench equals.
	task automatic expWr(input logic [7:0] a, input logic [7:0] v);
		shsp_wr_t w;
		w = (wq.size() > 0) ? wq.pop_front() : 16'h0000;
		chk(w, {a, v});
	endtask

	// Three-byte write from register ra; exp says whether the address is ours.
	task automatic i2cWr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d0, input logic exp);
		host.start();
		host.sendByte({dev, 1'b0}, ack);
		chk(16'(ack), 16'(exp));
		host.sendByte(ra, ack);
		chk(16'(ack), 16'(exp));
		for (int i = 0; i < 3; i++) begin
			host.sendByte(d0 + 8'(i), ack);
		end
		host.stop();
	endtask

	// Each strap setting: own address writes across the 0xFF wrap, the address of the inverted straps is ignored.
	task automatic testStraps();
		for (int s = 0; s < 4; s++) begin
			@(posedge sys_clk);
			strapLow <= s[0];
			strapHigh <= s[1];
			repeat (4) @(posedge sys_clk);
			i2cWr(7'h16 + 7'(s), 8'hFE, 8'h10 * 8'(s) + 8'h01, 1'b1);
			for (int i = 0; i < 3; i++) begin
				expWr(8'hFE + 8'(i), 8'h10 * 8'(s) + 8'h01 + 8'(i));
			end
			i2cWr(7'h16 + 7'(3 - s), 8'h80, 8'hEE, 1'b0);
			chk(16'(wq.size()), 16'h0000);
		end
	endtask

	// With the clock enable low the port is frozen, so even its own address gets no ack and no write.
	task automatic testFreeze();
		@(posedge sys_clk);
		ce <= 1'b0;
		i2cWr(7'h19, 8'h20, 8'h77, 1'b0);
		@(posedge sys_clk);
		ce <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk(16'(wq.size()), 16'h0000);
	endtask

	// Combined read at 0x19 of the last strap loop's bytes, across the wrap.
	task automatic testRead();
		host.start();
		host.sendByte({7'h19, 1'b0}, ack);
		host.sendByte(8'hFE, ack);
		host.start();
		host.sendByte({7'h19, 1'b1}, ack);
		chk(16'(ack), 16'h0001);
		for (int i = 0; i < 3; i++) begin
			host.recvByte(i < 2, d);
			chk(16'(d), 16'h0031 + 16'(i));
		end
		host.stop();
		chk(16'(sdaOe), 16'h0000);
		chk(16'(wq.size()), 16'h0000);
	endtask

	// Two-byte write then read-back in one clock mode; output enable around the frame.
	task automatic testSpi(input logic m);
		logic [7:0] v;
		v = 8'h5A ^ {8{m}};
		host.spiBegin(m);
		chk(16'(soOe), 16'h0000);
		host.spiByte(8'h00, d);
		chk(16'(soOe), 16'h0001);
		host.spiByte(8'h40, d);
		host.spiByte(v, d);
		host.spiByte(~v, d);
		host.spiEnd(m);
		expWr(8'h40, v);
		expWr(8'h41, ~v);
		host.spiBegin(m);
		host.spiByte(8'h01, d);
		host.spiByte(8'h40, d);
		host.spiByte(8'h00, d);
		chk(16'(d), 16'(v));
		host.spiByte(8'h00, d);
		chk(16'(d), {8'h00, ~v});
		host.spiEnd(m);
		chk(16'(soOe), 16'h0000);
	endtask

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Reset for five cycles, let the synchronisers settle, then run each scenario.
	initial begin
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		testStraps();
		testFreeze();
		testRead();
		testSpi(1'b0);
		testSpi(1'b1);
		final_report();
	end
endmodule // shsp_port_tb
